// file: rtl/break_match_pkg.sv
/*
 * Package for the bus cycle break matcher: register offsets, field
 * positions, reset values, qualifier encodings and the carrier structs.
 * Assumes a 32-bit APB register bus with word-aligned registers.
 */
`default_nettype none
package break_match_pkg;

    // =====================================================================
    // Register map (byte offsets on the APB bus)
    // =====================================================================
    localparam logic [7:0] OFF_ADDR_HIGH   = 8'h00;  // Break address high half.
    localparam logic [7:0] OFF_ADDR_LOW    = 8'h04;  // Break address low half.
    localparam logic [7:0] OFF_MASK_HIGH   = 8'h08;  // Address mask high half.
    localparam logic [7:0] OFF_MASK_LOW    = 8'h0C;  // Address mask low half.
    localparam logic [7:0] OFF_QUALIFIER   = 8'h10;  // Bus cycle qualifier.
    localparam logic [7:0] OFF_IRQ_STATUS  = 8'h14;  // Sticky event status.
    localparam logic [7:0] OFF_IRQ_MASK    = 8'h18;  // Interrupt enable mask.

    // =====================================================================
    // Reset values and field layout
    // =====================================================================
    localparam logic [15:0] REG_RESET      = 16'h0000;  // Every register resets to zero.
    localparam logic [1:0]  IRQ_RESET      = 2'h0;      // Status and mask reset value.
    localparam logic [15:0] QUAL_WR_MASK   = 16'h00FF;  // Only bits 7..0 are writable.
    localparam int          MASTER_POS     = 6;         // Master select field position.
    localparam int          KIND_POS       = 4;         // Fetch or data select position.
    localparam int          DIR_POS        = 2;         // Direction select position.
    localparam int          SIZE_POS       = 0;         // Size select position.
    localparam int          EVT_CPU_BIT    = 0;         // Status bit for a CPU cycle hit.
    localparam int          EVT_DMA_BIT    = 1;         // Status bit for a DMA cycle hit.

    // =====================================================================
    // Encodings
    // =====================================================================
    localparam logic [1:0] SEL_NONE        = 2'h0;  // No break / size ignored.
    localparam logic [1:0] SEL_FIRST       = 2'h1;  // CPU, fetch, read, or byte.
    localparam logic [1:0] SEL_SECOND      = 2'h2;  // DMA, data, write, or word.
    localparam logic [1:0] SEL_BOTH        = 2'h3;  // Both, or longword.

    // Operand size of an observed bus cycle.
    typedef enum logic [1:0]
    {
        SIZE_BYTE = 2'h1,
        SIZE_WORD = 2'h2,
        SIZE_LONG = 2'h3
    } op_size_type;

    // One observed bus cycle, as presented by the CPU or DMA side.
    typedef struct packed
    {
        logic        valid;    // A bus cycle starts in this clock.
        logic [31:0] address;  // Byte address of the cycle.
        logic        fetch;    // High for an instruction fetch.
        logic        write;    // High for a write cycle.
        logic [1:0]  size;     // Operand size, op_size_type encoding.
    } bus_cycle_type;

    // APB request bundle.
    typedef struct packed
    {
        logic        psel;     // Slave select.
        logic        penable;  // Access phase.
        logic        pwrite;   // Write direction.
        logic [7:0]  paddr;    // Byte address.
        logic [31:0] pwdata;   // Write data.
    } apb_req_type;

endpackage
`default_nettype wire

// file: rtl/bus_cycle_break_match.sv
/*
 * Bus cycle break matcher: break address, address mask and bus cycle
 * qualifier registers on APB, comparison against CPU and DMA bus cycles,
 * and a sticky, maskable break interrupt request.
 * Assumes both bus cycle streams are synchronous to pclk.
 */
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - High register holds address bits 31..16.
// - Low register holds address bits 15..0.
// - Five 16-bit registers, reset to zero.
// - Standby leaves all registers unchanged.
// - Mask one excludes address bit from compare.
// - Master select 00 none, CPU, DMA, both.
// - Access select 00 none, fetch, data, both.
// - Direction select 00 none, read, write, both.
// - Size select ignore, byte, word, longword.
// - Any 00 master, access or direction group blocks every break.
// - Qualifier bits 15..8 read zero; software writes zero.
// - Instruction fetches compare as word accesses.
// - Data accesses compare operand size, not bus width.
// - Full match raises break interrupt request.
module bus_cycle_break_match
    import break_match_pkg::*;
(
    input  wire logic        pclk,        // System clock, 40 MHz.
    input  wire logic        presetn,     // Asynchronous reset, active low.
    input  wire logic        psel,        // APB select.
    input  wire logic        penable,     // APB access phase.
    input  wire logic        pwrite,      // APB write direction.
    input  wire logic [7:0]  paddr,       // APB byte address.
    input  wire logic [31:0] pwdata,      // APB write data.
    output logic      [31:0] prdata,      // APB read data.
    output logic             pready,      // APB ready.
    output logic             pslverr,     // APB error for unmapped address.
    input  wire logic        standby,     // Standby mode indication.
    input  wire bus_cycle_type cpu_cycle, // Observed CPU bus cycle.
    input  wire bus_cycle_type dma_cycle, // Observed DMA bus cycle.
    output logic             break_irq    // Break interrupt request, level.
);

    // =====================================================================
    // State
    // =====================================================================
    // All state of the block in one record.
    typedef struct packed
    {
        logic [15:0] addr_high;   // Break address bits 31..16.
        logic [15:0] addr_low;    // Break address bits 15..0.
        logic [15:0] mask_high;   // Mask bits 31..16.
        logic [15:0] mask_low;    // Mask bits 15..0.
        logic [15:0] qualifier;   // Bus cycle qualifier, bits 7..0 used.
        logic [1:0]  irq_status;  // Sticky hits: CPU, DMA.
        logic [1:0]  irq_mask;    // Enables matching irq_status.
        logic [31:0] rdata;       // Registered read data.
    } state_type;

    state_type   cur;           // Registered state.
    state_type   next_state;    // Next state.
    apb_req_type req;           // Bundled APB request.
    logic        wr_en;         // Write accepted this clock.
    logic        rd_en;         // Read accepted this clock.
    logic        addr_ok;       // Address maps to a register.
    logic        cpu_hit;       // CPU cycle matches the break condition.
    logic        dma_hit;       // DMA cycle matches the break condition.
    logic [1:0]  hits;          // Hit events in status layout.
    logic [31:0] break_addr;    // Full break address.
    logic [31:0] break_mask;    // Full address mask.

    assign req = '{psel, penable, pwrite, paddr, pwdata};

    // =====================================================================
    // Match logic
    // =====================================================================
    // Tests one bus cycle against the programmed condition.
    function automatic logic cycle_match
    (
        input bus_cycle_type cyc,
        input logic          is_dma,
        input logic [31:0]   baddr,
        input logic [31:0]   bmask,
        input logic [15:0]   qual
    );
        logic [1:0] msel;
        logic [1:0] ksel;
        logic [1:0] dsel;
        logic [1:0] ssel;
        logic [1:0] eff_size;
        logic       m_ok;
        logic       k_ok;
        logic       d_ok;
        logic       s_ok;
        logic       a_ok;
        msel = qual[MASTER_POS +: 2];
        ksel = qual[KIND_POS +: 2];
        dsel = qual[DIR_POS +: 2];
        ssel = qual[SIZE_POS +: 2];
        // Master group: bit 0 enables CPU, bit 1 enables DMA; 00 blocks.
        m_ok = is_dma ? msel[1] : msel[0];
        // Access kind: bit 0 enables fetch, bit 1 enables data; 00 blocks.
        k_ok = cyc.fetch ? ksel[0] : ksel[1];
        // Direction: bit 0 enables read, bit 1 enables write; 00 blocks.
        d_ok = cyc.write ? dsel[1] : dsel[0];
        // Fetches count as word accesses; data uses its operand size.
        eff_size = cyc.fetch ? SIZE_WORD : cyc.size;
        s_ok = (ssel == SEL_NONE) || (ssel == eff_size);
        // Unmasked address bits must all be equal.
        a_ok = ((cyc.address ^ baddr) & ~bmask) == 32'h0000_0000;
        cycle_match = cyc.valid && m_ok && k_ok && d_ok && s_ok && a_ok;
    endfunction

    assign break_addr = {cur.addr_high, cur.addr_low};
    assign break_mask = {cur.mask_high, cur.mask_low};
    assign cpu_hit = cycle_match(cpu_cycle, 1'b0, break_addr, break_mask, cur.qualifier);
    assign dma_hit = cycle_match(dma_cycle, 1'b1, break_addr, break_mask, cur.qualifier);
    assign hits = {dma_hit, cpu_hit};

    // =====================================================================
    // APB decode
    // =====================================================================
    // Zero wait states: each access completes in its first access cycle.
    assign wr_en   = req.psel && req.penable && req.pwrite;
    assign rd_en   = req.psel && !req.penable && !req.pwrite;
    assign pready  = 1'b1;
    assign pslverr = req.psel && req.penable && !addr_ok;

    // Flags whether an address is mapped.
    always_comb
    begin
        if (req.paddr == OFF_ADDR_HIGH || req.paddr == OFF_ADDR_LOW)
        begin
            addr_ok = 1'b1;
        end
        else if (req.paddr == OFF_MASK_HIGH || req.paddr == OFF_MASK_LOW)
        begin
            addr_ok = 1'b1;
        end
        else if (req.paddr == OFF_QUALIFIER || req.paddr == OFF_IRQ_STATUS)
        begin
            addr_ok = 1'b1;
        end
        else if (req.paddr == OFF_IRQ_MASK)
        begin
            addr_ok = 1'b1;
        end
        else
        begin
            addr_ok = 1'b0;
        end
    end

    // =====================================================================
    // Next state
    // =====================================================================
    // Register writes, read data capture in setup phase, sticky events.
    // Standby has no term here, so contents are kept across it.
    always_comb
    begin
        next_state = cur;
        if (wr_en)
        begin
            if (req.paddr == OFF_ADDR_HIGH)
            begin
                next_state.addr_high = req.pwdata[15:0];
            end
            else if (req.paddr == OFF_ADDR_LOW)
            begin
                next_state.addr_low = req.pwdata[15:0];
            end
            else if (req.paddr == OFF_MASK_HIGH)
            begin
                next_state.mask_high = req.pwdata[15:0];
            end
            else if (req.paddr == OFF_MASK_LOW)
            begin
                next_state.mask_low = req.pwdata[15:0];
            end
            else if (req.paddr == OFF_QUALIFIER)
            begin
                // Reserved upper bits are never stored.
                next_state.qualifier = req.pwdata[15:0] & QUAL_WR_MASK;
            end
            else if (req.paddr == OFF_IRQ_STATUS)
            begin
                // Write one to clear.
                next_state.irq_status = cur.irq_status & ~req.pwdata[1:0];
            end
            else if (req.paddr == OFF_IRQ_MASK)
            begin
                next_state.irq_mask = req.pwdata[1:0];
            end
            else
            begin
                next_state.irq_mask = cur.irq_mask;
            end
        end
        // A hit in the clearing cycle wins over the clear.
        next_state.irq_status = next_state.irq_status | hits;
        if (rd_en)
        begin
            if (req.paddr == OFF_ADDR_HIGH)
            begin
                next_state.rdata = {16'h0000, cur.addr_high};
            end
            else if (req.paddr == OFF_ADDR_LOW)
            begin
                next_state.rdata = {16'h0000, cur.addr_low};
            end
            else if (req.paddr == OFF_MASK_HIGH)
            begin
                next_state.rdata = {16'h0000, cur.mask_high};
            end
            else if (req.paddr == OFF_MASK_LOW)
            begin
                next_state.rdata = {16'h0000, cur.mask_low};
            end
            else if (req.paddr == OFF_QUALIFIER)
            begin
                next_state.rdata = {16'h0000, cur.qualifier & QUAL_WR_MASK};
            end
            else if (req.paddr == OFF_IRQ_STATUS)
            begin
                next_state.rdata = {30'h0000_0000, cur.irq_status};
            end
            else if (req.paddr == OFF_IRQ_MASK)
            begin
                next_state.rdata = {30'h0000_0000, cur.irq_mask};
            end
            else
            begin
                next_state.rdata = 32'h0000_0000;
            end
        end
    end

    // =====================================================================
    // State register
    // =====================================================================
    // Reset clears every register to zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur <= '{REG_RESET, REG_RESET, REG_RESET, REG_RESET, REG_RESET,
                     IRQ_RESET, IRQ_RESET, 32'h0000_0000};
        end
        else
        begin
            cur <= next_state;
        end
    end

    assign prdata    = cur.rdata;
    assign break_irq = |(cur.irq_status & cur.irq_mask);

    // =====================================================================
    // Checks
    // =====================================================================
    // A CPU hit sets its status bit on the next edge.
    a_cpu_hit_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_hit |=> cur.irq_status[EVT_CPU_BIT])
        else $error("CPU hit did not set status");

    // A DMA hit sets its status bit on the next edge.
    a_dma_hit_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        dma_hit |=> cur.irq_status[EVT_DMA_BIT])
        else $error("DMA hit did not set status");

    // A zero master, access or direction group never yields a hit.
    a_zero_group_blocks: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.qualifier[7:6] == SEL_NONE || cur.qualifier[5:4] == SEL_NONE
         || cur.qualifier[3:2] == SEL_NONE) |-> !(cpu_hit || dma_hit))
        else $error("Hit with a blocked group");

    // CPU only master select never matches DMA cycles.
    a_master_cpu_only: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.qualifier[7:6] == SEL_FIRST) |-> !dma_hit)
        else $error("DMA hit with CPU only select");

    // Fetch only select never matches data cycles.
    a_kind_fetch_only: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.qualifier[5:4] == SEL_FIRST && !cpu_cycle.fetch) |-> !cpu_hit)
        else $error("Data hit with fetch only select");

    // Read only select never matches writes.
    a_dir_read_only: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.qualifier[3:2] == SEL_FIRST && cpu_cycle.write) |-> !cpu_hit)
        else $error("Write hit with read only select");

    // A fetch with longword size select never matches.
    a_fetch_is_word: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.qualifier[1:0] == SEL_BOTH && cpu_cycle.fetch) |-> !cpu_hit)
        else $error("Fetch matched longword size");

    // Data size must equal the selected size when a hit occurs.
    a_size_matches: assert property (@(posedge pclk) disable iff (!presetn)
        (cpu_hit && !cpu_cycle.fetch && cur.qualifier[1:0] != SEL_NONE)
        |-> cpu_cycle.size == cur.qualifier[1:0])
        else $error("Hit with wrong operand size");

    // An unmasked differing address bit prevents a hit.
    a_addr_compare: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_hit |-> ((cpu_cycle.address ^ break_addr) & ~break_mask) == 32'h0)
        else $error("Hit with unequal address");

    // Reserved qualifier bits always read zero.
    a_qual_reserved: assert property (@(posedge pclk) disable iff (!presetn)
        cur.qualifier[15:8] == 8'h00)
        else $error("Reserved qualifier bits set");

    // Written address appears in the register after the write.
    a_addr_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && req.paddr == OFF_ADDR_HIGH)
        |=> cur.addr_high == $past(req.pwdata[15:0]))
        else $error("High address write lost");

    // Standby alone does not change configuration.
    a_standby_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        (standby && !wr_en) |=> $stable(cur.qualifier) && $stable(cur.mask_low))
        else $error("Registers changed in standby");

    // DMA only master select never matches CPU cycles.
    a_master_dma_only: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.qualifier[7:6] == SEL_SECOND) |-> !cpu_hit)
        else $error("CPU hit with DMA only select");

    // Data only select never matches fetches.
    a_kind_data_only: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.qualifier[5:4] == SEL_SECOND && cpu_cycle.fetch) |-> !cpu_hit)
        else $error("Fetch hit with data only select");

    // Write only select never matches reads.
    a_dir_write_only: assert property (@(posedge pclk) disable iff (!presetn)
        (cur.qualifier[3:2] == SEL_SECOND && !cpu_cycle.write) |-> !cpu_hit)
        else $error("Read hit with write only select");

    // A DMA hit needs every unmasked address bit equal.
    a_dma_addr_compare: assert property (@(posedge pclk) disable iff (!presetn)
        dma_hit
        |-> ((dma_cycle.address ^ break_addr) & ~break_mask) == 32'h0)
        else $error("DMA hit with unequal address");

    // A DMA hit carries the selected operand size.
    a_dma_size: assert property (@(posedge pclk) disable iff (!presetn)
        (dma_hit && !dma_cycle.fetch && cur.qualifier[1:0] != SEL_NONE)
        |-> dma_cycle.size == cur.qualifier[1:0])
        else $error("DMA hit with wrong size");

    // Written low address appears in the register.
    a_low_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && req.paddr == OFF_ADDR_LOW)
        |=> cur.addr_low == $past(req.pwdata[15:0]))
        else $error("Low address write lost");

    // Written high mask appears in the register.
    a_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && req.paddr == OFF_MASK_HIGH)
        |=> cur.mask_high == $past(req.pwdata[15:0]))
        else $error("High mask write lost");

    // Written qualifier bits 7..0 are stored.
    a_qual_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && req.paddr == OFF_QUALIFIER)
        |=> cur.qualifier[7:0] == $past(req.pwdata[7:0]))
        else $error("Qualifier write lost");

    // An enabled DMA hit raises the request on the next edge.
    a_irq_raise: assert property (@(posedge pclk) disable iff (!presetn)
        (dma_hit && cur.irq_mask[EVT_DMA_BIT] && !wr_en)
        |=> break_irq)
        else $error("Enabled hit raised no request");

endmodule
`default_nettype wire

// file: tb/bus_cycle_break_match_tb.sv
/*
 * Self-checking bench for the break matcher: registers over APB,
 * interrupt status and mask, and a sweep of 192 of the 256 qualifier values.
 * Assumes the partner model in bus_cycle_source.sv.
 */
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_break_match_tb;
    import break_match_pkg::*;
    logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic          standby, req_dma, req_go, break_irq;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata;
    bus_cycle_type req, cpu_cycle, dma_cycle;
    int            n_errors, n_tests;

    // =====================================================================
    // Instances and clock
    // =====================================================================
    bus_cycle_break_match bus_cycle_break_match_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .standby(standby),
        .cpu_cycle(cpu_cycle), .dma_cycle(dma_cycle), .break_irq(break_irq));
    bus_cycle_source bus_cycle_source_i (.pclk(pclk), .presetn(presetn), .req(req),
        .req_dma(req_dma), .req_go(req_go), .cpu_cycle(cpu_cycle), .dma_cycle(dma_cycle));
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // =====================================================================
    // Shared tasks
    // =====================================================================
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; the request holds until pready is seen high, or the run ends after 8 clocks without it.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 8; k++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 8)
        begin
            n_errors++;
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
        chk({31'h0, e}, {31'h0, exp_err});
    endtask
    task automatic cfg(input logic [15:0] ah, al, mh, ml, q);
        wr(OFF_ADDR_HIGH, {16'h0, ah});
        wr(OFF_ADDR_LOW, {16'h0, al});
        wr(OFF_MASK_HIGH, {16'h0, mh});
        wr(OFF_MASK_LOW, {16'h0, ml});
        wr(OFF_QUALIFIER, {16'h0, q});
    endtask
    // Issues one bus cycle, checks the request line, then clears status.
    task automatic hit(input logic [31:0] a, input logic f, w, input logic [1:0] s,
                       input logic dma, input logic exp);
        @(posedge pclk);
        req <= '{1'b1, a, f, w, s};
        req_dma <= dma;
        req_go <= 1'b1;
        @(posedge pclk);
        req_go <= 1'b0;
        @(posedge pclk);
        #1;
        chk({31'h0, break_irq}, {31'h0, exp});
        wr(OFF_IRQ_STATUS, 32'h3);
    endtask
    // Expected match worked out from the qualifier fields.
    function automatic logic ref_hit(logic [7:0] q, logic [31:0] a, logic f, w,
                                     logic [1:0] s, logic dma, logic [31:0] ba, bm);
        logic [1:0] sz;
        sz = f ? 2'h2 : s;
        return (dma ? q[7] : q[6]) && (f ? q[4] : q[5]) && (w ? q[3] : q[2])
            && (q[1:0] == 2'h0 || q[1:0] == sz) && (((a ^ ba) & ~bm) == 32'h0);
    endfunction

    // =====================================================================
    // Scenarios
    // =====================================================================
    task automatic t_regs();
        logic [7:0] offs[5] = '{OFF_ADDR_HIGH, OFF_ADDR_LOW, OFF_MASK_HIGH,
                                OFF_MASK_LOW, OFF_QUALIFIER};
        foreach (offs[i])
            rd(offs[i], 32'h0, 1'b0);
        rd(OFF_IRQ_STATUS, 32'h0, 1'b0);
        rd(OFF_IRQ_MASK, 32'h0, 1'b0);
        foreach (offs[i])
            wr(offs[i], 32'hFFFF_FFFF);
        standby <= 1'b1;
        foreach (offs[i])
            rd(offs[i], (i == 4) ? 32'h0000_00FF : 32'h0000_FFFF, 1'b0);
        standby <= 1'b0;
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, 32'h0, 1'b1);
        $display("register test done");
    endtask
    task automatic t_irq();
        cfg(16'h0, 16'h0, 16'h0, 16'h0, 16'h00EC);
        hit(32'h0, 1'b0, 1'b0, 2'h3, 1'b0, 1'b0);
        hit(32'h0, 1'b0, 1'b0, 2'h3, 1'b0, 1'b0);
        @(posedge pclk);
        req <= '{1'b1, 32'h0, 1'b0, 1'b1, 2'h1};
        req_dma <= 1'b1;
        req_go <= 1'b1;
        @(posedge pclk);
        req_go <= 1'b0;
        rd(OFF_IRQ_STATUS, 32'h2, 1'b0);
        chk({31'h0, break_irq}, 32'h0);
        wr(OFF_IRQ_MASK, 32'h2);
        #1;
        chk({31'h0, break_irq}, 32'h1);
        wr(OFF_IRQ_STATUS, 32'h2);
        #1;
        chk({31'h0, break_irq}, 32'h0);
        rd(OFF_IRQ_STATUS, 32'h0, 1'b0);
        wr(OFF_IRQ_MASK, 32'h3);
        $display("interrupt test done");
    endtask
    task automatic t_mask();
        cfg(16'h0001, 16'h0000, 16'h8000, 16'h0000, 16'h00EC);
        hit(32'h8001_0000, 1'b0, 1'b0, 2'h3, 1'b0, 1'b1);
        hit(32'h4001_0000, 1'b0, 1'b0, 2'h3, 1'b0, 1'b0);
        hit(32'h0001_0001, 1'b0, 1'b1, 2'h1, 1'b1, 1'b0);
        wr(OFF_MASK_LOW, 32'h1);
        hit(32'h0001_0001, 1'b0, 1'b1, 2'h1, 1'b1, 1'b1);
        $display("mask test done");
    endtask
    task automatic t_matrix();
        logic [31:0] a;
        logic        d, f, w;
        logic [1:0]  s;
        a = 32'h1234_5678;
        cfg(16'h1234, 16'h5678, 16'h0, 16'h0, 16'h0);
        for (int q = 0; q < 256; q++)
        begin
            if (q[4] && q[0])
                continue;
            wr(OFF_QUALIFIER, q);
            for (int n = 0; n < 16; n++)
            begin
                {d, f, w, s} = {n[3:1], 2'h1 + 2'(n[0])};
                if (d && f)
                    continue;
                hit(a, f, w, s, d, ref_hit(q[7:0], a, f, w, s, d, a, 32'h0));
                if (!f && s == 2'h2)
                    hit(a, f, w, 2'h3, d, ref_hit(q[7:0], a, f, w, 2'h3, d, a, 32'h0));
            end
        end
        $display("qualifier sweep done");
    endtask

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial
    begin
        {presetn, psel, penable, pwrite, standby, req_dma, req_go} = '0;
        {paddr, pwdata, req, n_errors, n_tests} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_irq();
        t_mask();
        t_matrix();
        close_out();
    end
endmodule
`default_nettype wire

// file: tb/bus_cycle_source.sv
/*
 * Model of the far side: issues CPU and DMA bus cycles one clock long.
 * Assumes the bench raises go for one clock with the cycle on req.
 */
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_source
    import break_match_pkg::*;
(
    input  wire logic          pclk,      // System clock.
    input  wire logic          presetn,   // Asynchronous reset, active low.
    input  wire bus_cycle_type req,       // Cycle to issue.
    input  wire logic          req_dma,   // High to issue it as a DMA cycle.
    input  wire logic          req_go,    // Issue request, one clock.
    output bus_cycle_type      cpu_cycle, // CPU bus cycle stream.
    output bus_cycle_type      dma_cycle  // DMA bus cycle stream.
);
    // =====================================================================
    // Cycle streams
    // =====================================================================
    // Idle streams flip their address so a stale value never looks valid.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_cycle <= '0;
            dma_cycle <= '0;
        end
        else
        begin
            cpu_cycle.valid   <= 1'b0;
            dma_cycle.valid   <= 1'b0;
            cpu_cycle.address <= ~cpu_cycle.address;
            dma_cycle.address <= ~dma_cycle.address;
            if (req_go && !req_dma)
                cpu_cycle <= req;
            if (req_go && req_dma)
                dma_cycle <= req;
        end
    end
endmodule
`default_nettype wire
